// file: src/cbs_sequencer.v
`include "cbs_regs.vh"
module cbs_sequencer (
    input  wire                     clk,
    input  wire                     rst,
    input  wire [`CBS_GRP_W-1:0]    group,
    input  wire                     zero_minus_test_op,
    input  wire [15:0]              index_reg,
    input  wire [15:0]              stack_ptr,
    input  wire [15:0]              store_word,
    input  wire [7:0]               data_in,
    output reg  [15:0]              addr_q,
    output reg                      valid_memory_address_qualifier,
    output reg                      rw_read_q,
    output reg  [7:0]               data_out_q,
    output reg                      data_oe_q,
    output reg  [1:0]               data_use_q,
    output reg                      opcode_fetch_q,
    output reg                      instr_done_q,
    output reg  [15:0]              pc_q
);
    localparam [1:0] ST_FETCH = 2'b01;
    localparam [1:0] ST_EXEC  = 2'b10;
    reg  [1:0]          state_q;
    reg  [2:0]          step_q;
    reg  [2:0]          step_d;
    reg  [`CBS_GRP_W-1:0] grp_q;
    reg  [15:0]         opa_q;
    reg  [7:0]          off_q;
    reg  [6:0]          rom_addr;
    wire [`CBS_UW-1:0]  uw;
    wire                u_last;
    wire                u_vma;
    wire                u_rw;
    wire [2:0]          u_src;
    wire [1:0]          u_dat;
    wire                u_pinc;
    wire                u_lhi;
    wire                u_llo;
    wire [15:0]         ixo;
    wire                is_rmw;
    reg  [15:0]         a_d;
    reg  [15:0]         ret_q;
    wire                u_alt;
    wire                ext_grp;
    wire [15:0]         opa_now;
    wire [7:0]          off_now;
    wire [15:0]         ixc;
    wire [15:0]         fetch_pc;
    reg                 lhi_q;
    reg                 llo_q;

    // Rows are fetched one cycle early, so the ROM is addressed with the coming step.
    always @* begin
        step_d = (state_q == ST_FETCH) ? 3'h0 : step_q + 3'h1;
        rom_addr = (state_q == ST_FETCH) ? {group[3:0], step_d} : {grp_q[3:0], step_d};
        if ((state_q == ST_FETCH && group[4]) || (state_q != ST_FETCH && grp_q[4])) begin
            // Extended store and modify share the extended jump's two address fetches, then a tail.
            rom_addr = {4'hd, step_d};
        end
    end

    cbs_rom u_rom (
        .clk    (clk),
        .addr   (rom_addr),
        .data_q (uw)
    );

    assign {u_last, u_vma, u_rw, u_src, u_dat, u_pinc, u_lhi, u_llo, u_alt} = uw;
    // A byte read in one cycle is sampled at the edge that ends it, which may already need it as address.
    assign ext_grp = (grp_q >= `CBS_GRP_EXT_JMP);
    assign opa_now[15:8] = lhi_q ? data_in : (llo_q && !ext_grp) ? 8'h00 : opa_q[15:8];
    assign opa_now[7:0] = llo_q ? data_in : opa_q[7:0];
    assign off_now = (llo_q && !ext_grp) ? data_in : off_q;
    // Index plus offset wraps within 16 bits: the carry out is dropped on purpose.
    assign ixo = index_reg + {8'h00, off_now};
    assign ixc = {index_reg[15:8], index_reg[7:0] + off_now};
    assign fetch_pc = (llo_q && grp_q == `CBS_GRP_EXT_JMP) ? opa_now : pc_q;
    assign is_rmw = (grp_q == `CBS_GRP_IDX_RMW) || (grp_q == `CBS_GRP_EXT_RMW);

    always @* begin
        case (u_src)
            `CBS_SRC_PC:   a_d = pc_q;
            `CBS_SRC_OPA:  a_d = opa_now;
            `CBS_SRC_OPA1: a_d = opa_now + 16'h0001;
            `CBS_SRC_IX:   a_d = index_reg;
            `CBS_SRC_IXO:  a_d = u_alt ? ixc : ixo;
            `CBS_SRC_IXO1: a_d = ixo + 16'h0001;
            `CBS_SRC_SP:   a_d = stack_ptr;
            `CBS_SRC_SPM1: a_d = u_alt ? stack_ptr - 16'h0002 : stack_ptr - 16'h0001;
            default:       a_d = pc_q;
        endcase
    end

    // Extended read-modify-write and accumulator stores reuse extended rows plus tails.
    // This path keeps the ROM compact by sharing the two address fetches.
    reg  [2:0] ext_tail_q;

    always @(posedge clk) begin
        if (rst) begin
            state_q  <= ST_FETCH;
            step_q   <= 3'h0;
            grp_q    <= {`CBS_GRP_W{1'b0}};
            opa_q    <= 16'h0000;
            off_q    <= 8'h00;
            pc_q     <= 16'h0000;
            ret_q    <= 16'h0000;
            addr_q   <= 16'h0000;
            valid_memory_address_qualifier <= 1'b0;
            rw_read_q <= 1'b1;
            data_out_q <= 8'h00;
            data_oe_q <= 1'b0;
            data_use_q <= `CBS_DAT_NONE;
            opcode_fetch_q <= 1'b0;
            instr_done_q <= 1'b0;
            ext_tail_q <= 3'h0;
            lhi_q    <= 1'b0;
            llo_q    <= 1'b0;
        end else begin
            instr_done_q   <= 1'b0;
            opcode_fetch_q <= 1'b0;
            opa_q          <= opa_now;
            off_q          <= off_now;
            lhi_q          <= 1'b0;
            llo_q          <= 1'b0;
            case (state_q)
                ST_FETCH: begin
                    // Opcode fetch at the current pc, qualifier high, read.
                    addr_q    <= fetch_pc;
                    valid_memory_address_qualifier <= 1'b1;
                    rw_read_q <= 1'b1;
                    data_oe_q <= 1'b0;
                    data_use_q <= `CBS_DAT_READ;
                    opcode_fetch_q <= 1'b1;
                    pc_q      <= fetch_pc + 16'h0001;
                    grp_q     <= group;
                    step_q    <= 3'h0;
                    ext_tail_q <= 3'h0;
                    state_q   <= ST_EXEC;
                end
                ST_EXEC: begin
                    if (ext_tail_q != 3'h0) begin
                        // Extended store and modify tails after the two address fetches.
                        addr_q <= opa_now;
                        ext_tail_q <= ext_tail_q - 3'h1;
                        if (grp_q == `CBS_GRP_EXT_STA) begin
                            valid_memory_address_qualifier <= (ext_tail_q == 3'h1);
                            rw_read_q  <= (ext_tail_q != 3'h1);
                            data_oe_q  <= (ext_tail_q == 3'h1);
                            data_use_q <= (ext_tail_q == 3'h1) ? `CBS_DAT_WLO : `CBS_DAT_NONE;
                        end else begin
                            // Test op never qualifies its final write.
                            valid_memory_address_qualifier <= (ext_tail_q == 3'h3) ||
                                ((ext_tail_q == 3'h1) && !zero_minus_test_op);
                            rw_read_q  <= (ext_tail_q != 3'h1);
                            data_oe_q  <= (ext_tail_q == 3'h1);
                            data_use_q <= (ext_tail_q == 3'h3) ? `CBS_DAT_READ :
                                          (ext_tail_q == 3'h1) ? `CBS_DAT_WLO : `CBS_DAT_NONE;
                        end
                        data_out_q <= store_word[7:0];
                        if (ext_tail_q == 3'h1) begin
                            instr_done_q <= 1'b1;
                            state_q <= ST_FETCH;
                        end
                    end else begin
                        // Each cycle drives address, qualifier and direction.
                        step_q    <= step_d;
                        addr_q    <= a_d;
                        valid_memory_address_qualifier <= u_vma &&
                            !(is_rmw && u_last && !u_rw && zero_minus_test_op);
                        rw_read_q <= u_rw;
                        data_oe_q <= !u_rw;
                        data_use_q <= u_dat;
                        if (u_dat == `CBS_DAT_WHI) begin
                            data_out_q <= (grp_q == `CBS_GRP_IDX_JSR) ? ret_q[15:8] : store_word[15:8];
                        end else begin
                            data_out_q <= (grp_q == `CBS_GRP_IDX_JSR) ? ret_q[7:0] : store_word[7:0];
                        end
                        if (u_pinc) begin
                            pc_q <= pc_q + 16'h0001;
                            ret_q <= pc_q + 16'h0001;
                        end
                        lhi_q <= u_lhi;
                        llo_q <= u_llo;
                        if (u_last) begin
                            if (grp_q == `CBS_GRP_EXT_STA) begin
                                ext_tail_q <= 3'h2;
                            end else if (grp_q == `CBS_GRP_EXT_RMW) begin
                                ext_tail_q <= 3'h3;
                            end else begin
                                instr_done_q <= 1'b1;
                                state_q <= ST_FETCH;
                            end
                            if (grp_q == `CBS_GRP_IDX_JMP || grp_q == `CBS_GRP_IDX_JSR) begin
                                pc_q <= ixo;
                            end
                        end
                    end
                end
                default: begin
                    state_q <= ST_FETCH;
                end
            endcase
        end
    end
    // Cycle counts per group are set by the ROM rows, plus the tail cycles for the extended store and modify groups.
endmodule

// file: pkg/cbs_regs.vh
`ifndef CBS_REGS_VH
`define CBS_REGS_VH
// Instruction groups presented on the group input.
`define CBS_GRP_IMM8     4'h0
`define CBS_GRP_IMM16    4'h1
`define CBS_GRP_DIR8     4'h2
`define CBS_GRP_DIR16    4'h3
`define CBS_GRP_DIR_STA  4'h4
`define CBS_GRP_DIR_STR  4'h5
`define CBS_GRP_IDX_JMP  4'h6
`define CBS_GRP_IDX8     4'h7
`define CBS_GRP_IDX16    4'h8
`define CBS_GRP_IDX_STA  4'h9
`define CBS_GRP_IDX_RMW  4'ha
`define CBS_GRP_IDX_STR  4'hb
`define CBS_GRP_IDX_JSR  4'hc
`define CBS_GRP_EXT_JMP  4'hd
`define CBS_GRP_EXT8     4'he
`define CBS_GRP_EXT16    4'hf
`define CBS_GRP_EXT_STA  5'h10
`define CBS_GRP_EXT_RMW  5'h11
`define CBS_GRP_W        5
// Address source selects.
`define CBS_SRC_PC       3'h0
`define CBS_SRC_OPA      3'h1
`define CBS_SRC_OPA1     3'h2
`define CBS_SRC_IX       3'h3
`define CBS_SRC_IXO      3'h4
`define CBS_SRC_IXO1     3'h5
`define CBS_SRC_SP       3'h6
`define CBS_SRC_SPM1     3'h7
// Data bus meaning.
`define CBS_DAT_NONE     2'h0
`define CBS_DAT_READ     2'h1
`define CBS_DAT_WHI      2'h2
`define CBS_DAT_WLO      2'h3
// Microcode word: last, vma, rw, src, dat, pc_inc, lat_hi, lat_lo, alt.
`define CBS_UW           12
`define CBS_ROM_DEPTH    128
`endif

// file: src/cbs_rom.v
`include "cbs_regs.vh"
// Per-cycle control ROM; registered output so the step is read one cycle ahead.
module cbs_rom (
    input  wire                 clk,
    input  wire [6:0]           addr,
    output reg  [`CBS_UW-1:0]   data_q
);
    reg [`CBS_UW-1:0] word;
    // Fields: last, vma, rw, src[2:0], dat[1:0], pc_inc, lat_hi, lat_lo, alt.
    // The alt bit picks the sum before the carry for the index source, or two below the stack pointer.
    function [`CBS_UW-1:0] u;
        input l;
        input v;
        input r;
        input [2:0] s;
        input [1:0] d;
        input p;
        input h;
        input o;
        begin
            u = {l, v, r, s, d, p, h, o, 1'b0};
        end
    endfunction
    always @* begin
        word = u(1'b1, 1'b1, 1'b1, `CBS_SRC_PC, `CBS_DAT_READ, 1'b1, 1'b0, 1'b0);
        case (addr)
            // Immediate 8-bit.
            7'h00: word = u(1, 1, 1, `CBS_SRC_PC, `CBS_DAT_READ, 1, 0, 0);
            // Immediate 16-bit.
            7'h08: word = u(0, 1, 1, `CBS_SRC_PC, `CBS_DAT_READ, 1, 0, 0);
            7'h09: word = u(1, 1, 1, `CBS_SRC_PC, `CBS_DAT_READ, 1, 0, 0);
            // Direct 8-bit.
            7'h10: word = u(0, 1, 1, `CBS_SRC_PC, `CBS_DAT_READ, 1, 0, 1);
            7'h11: word = u(1, 1, 1, `CBS_SRC_OPA, `CBS_DAT_READ, 0, 0, 0);
            // Direct 16-bit.
            7'h18: word = u(0, 1, 1, `CBS_SRC_PC, `CBS_DAT_READ, 1, 0, 1);
            7'h19: word = u(0, 1, 1, `CBS_SRC_OPA, `CBS_DAT_READ, 0, 0, 0);
            7'h1a: word = u(1, 1, 1, `CBS_SRC_OPA1, `CBS_DAT_READ, 0, 0, 0);
            // Direct accumulator store.
            7'h20: word = u(0, 1, 1, `CBS_SRC_PC, `CBS_DAT_READ, 1, 0, 1);
            7'h21: word = u(0, 0, 1, `CBS_SRC_OPA, `CBS_DAT_NONE, 0, 0, 0);
            7'h22: word = u(1, 1, 0, `CBS_SRC_OPA, `CBS_DAT_WLO, 0, 0, 0);
            // Direct register store.
            7'h28: word = u(0, 1, 1, `CBS_SRC_PC, `CBS_DAT_READ, 1, 0, 1);
            7'h29: word = u(0, 0, 1, `CBS_SRC_OPA, `CBS_DAT_NONE, 0, 0, 0);
            7'h2a: word = u(0, 1, 0, `CBS_SRC_OPA, `CBS_DAT_WHI, 0, 0, 0);
            7'h2b: word = u(1, 1, 0, `CBS_SRC_OPA1, `CBS_DAT_WLO, 0, 0, 0);
            // Indexed jump.
            7'h30: word = u(0, 1, 1, `CBS_SRC_PC, `CBS_DAT_READ, 1, 0, 1);
            7'h31: word = u(0, 0, 1, `CBS_SRC_IX, `CBS_DAT_NONE, 0, 0, 0);
            7'h32: word = u(1, 0, 1, `CBS_SRC_IXO, `CBS_DAT_NONE, 0, 0, 0) | 12'h001;
            // Indexed 8-bit read.
            7'h38: word = u(0, 1, 1, `CBS_SRC_PC, `CBS_DAT_READ, 1, 0, 1);
            7'h39: word = u(0, 0, 1, `CBS_SRC_IX, `CBS_DAT_NONE, 0, 0, 0);
            7'h3a: word = u(0, 0, 1, `CBS_SRC_IXO, `CBS_DAT_NONE, 0, 0, 0) | 12'h001;
            7'h3b: word = u(1, 1, 1, `CBS_SRC_IXO, `CBS_DAT_READ, 0, 0, 0);
            // Indexed 16-bit read.
            7'h40: word = u(0, 1, 1, `CBS_SRC_PC, `CBS_DAT_READ, 1, 0, 1);
            7'h41: word = u(0, 0, 1, `CBS_SRC_IX, `CBS_DAT_NONE, 0, 0, 0);
            7'h42: word = u(0, 0, 1, `CBS_SRC_IXO, `CBS_DAT_NONE, 0, 0, 0) | 12'h001;
            7'h43: word = u(0, 1, 1, `CBS_SRC_IXO, `CBS_DAT_READ, 0, 0, 0);
            7'h44: word = u(1, 1, 1, `CBS_SRC_IXO1, `CBS_DAT_READ, 0, 0, 0);
            // Indexed accumulator store.
            7'h48: word = u(0, 1, 1, `CBS_SRC_PC, `CBS_DAT_READ, 1, 0, 1);
            7'h49: word = u(0, 0, 1, `CBS_SRC_IX, `CBS_DAT_NONE, 0, 0, 0);
            7'h4a: word = u(0, 0, 1, `CBS_SRC_IXO, `CBS_DAT_NONE, 0, 0, 0) | 12'h001;
            7'h4b: word = u(0, 0, 1, `CBS_SRC_IXO, `CBS_DAT_NONE, 0, 0, 0);
            7'h4c: word = u(1, 1, 0, `CBS_SRC_IXO, `CBS_DAT_WLO, 0, 0, 0);
            // Indexed read-modify-write.
            7'h50: word = u(0, 1, 1, `CBS_SRC_PC, `CBS_DAT_READ, 1, 0, 1);
            7'h51: word = u(0, 0, 1, `CBS_SRC_IX, `CBS_DAT_NONE, 0, 0, 0);
            7'h52: word = u(0, 0, 1, `CBS_SRC_IXO, `CBS_DAT_NONE, 0, 0, 0) | 12'h001;
            7'h53: word = u(0, 1, 1, `CBS_SRC_IXO, `CBS_DAT_READ, 0, 0, 0);
            7'h54: word = u(0, 0, 1, `CBS_SRC_IXO, `CBS_DAT_NONE, 0, 0, 0);
            7'h55: word = u(1, 1, 0, `CBS_SRC_IXO, `CBS_DAT_WLO, 0, 0, 0);
            // Indexed register store.
            7'h58: word = u(0, 1, 1, `CBS_SRC_PC, `CBS_DAT_READ, 1, 0, 1);
            7'h59: word = u(0, 0, 1, `CBS_SRC_IX, `CBS_DAT_NONE, 0, 0, 0);
            7'h5a: word = u(0, 0, 1, `CBS_SRC_IXO, `CBS_DAT_NONE, 0, 0, 0) | 12'h001;
            7'h5b: word = u(0, 0, 1, `CBS_SRC_IXO, `CBS_DAT_NONE, 0, 0, 0);
            7'h5c: word = u(0, 1, 0, `CBS_SRC_IXO, `CBS_DAT_WHI, 0, 0, 0);
            7'h5d: word = u(1, 1, 0, `CBS_SRC_IXO1, `CBS_DAT_WLO, 0, 0, 0);
            // Indexed subroutine call; return address is the pc after the offset.
            7'h60: word = u(0, 1, 1, `CBS_SRC_PC, `CBS_DAT_READ, 1, 0, 1);
            7'h61: word = u(0, 0, 1, `CBS_SRC_IX, `CBS_DAT_NONE, 0, 0, 0);
            7'h62: word = u(0, 1, 0, `CBS_SRC_SP, `CBS_DAT_WLO, 0, 0, 0);
            7'h63: word = u(0, 1, 0, `CBS_SRC_SPM1, `CBS_DAT_WHI, 0, 0, 0);
            7'h64: word = u(0, 0, 1, `CBS_SRC_SPM1, `CBS_DAT_NONE, 0, 0, 0) | 12'h001;
            7'h65: word = u(0, 0, 1, `CBS_SRC_IX, `CBS_DAT_NONE, 0, 0, 0);
            7'h66: word = u(1, 0, 1, `CBS_SRC_IXO, `CBS_DAT_NONE, 0, 0, 0) | 12'h001;
            // Extended jump.
            7'h68: word = u(0, 1, 1, `CBS_SRC_PC, `CBS_DAT_READ, 1, 1, 0);
            7'h69: word = u(1, 1, 1, `CBS_SRC_PC, `CBS_DAT_READ, 1, 0, 1);
            // Extended 8-bit read.
            7'h70: word = u(0, 1, 1, `CBS_SRC_PC, `CBS_DAT_READ, 1, 1, 0);
            7'h71: word = u(0, 1, 1, `CBS_SRC_PC, `CBS_DAT_READ, 1, 0, 1);
            7'h72: word = u(1, 1, 1, `CBS_SRC_OPA, `CBS_DAT_READ, 0, 0, 0);
            // Extended 16-bit read.
            7'h78: word = u(0, 1, 1, `CBS_SRC_PC, `CBS_DAT_READ, 1, 1, 0);
            7'h79: word = u(0, 1, 1, `CBS_SRC_PC, `CBS_DAT_READ, 1, 0, 1);
            7'h7a: word = u(0, 1, 1, `CBS_SRC_OPA, `CBS_DAT_READ, 0, 0, 0);
            7'h7b: word = u(1, 1, 1, `CBS_SRC_OPA1, `CBS_DAT_READ, 0, 0, 0);
            default: word = u(1, 1, 1, `CBS_SRC_PC, `CBS_DAT_READ, 1, 0, 0);
        endcase
    end
    always @(posedge clk) begin
        data_q <= word;
    end
endmodule

// file: tb/cbs_seq_sva.sv
module cbs_seq_sva (
    input wire logic        clk,
    input wire logic        rst,
    input wire logic [15:0] addr_q,
    input wire logic        valid_memory_address_qualifier,
    input wire logic        rw_read_q,
    input wire logic        data_oe_q,
    input wire logic        opcode_fetch_q,
    input wire logic        instr_done_q
);
    timeunit 1ns;
    timeprecision 1ns;
    logic qual;
    logic wr;
    assign qual = valid_memory_address_qualifier;
    assign wr = valid_memory_address_qualifier && !rw_read_q;
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (rst);
    a_idle_reads: assert property (!qual && !instr_done_q |-> rw_read_q)
        else $error("Read select dropped in an idle cycle.");
    a_fetch_reads: assert property (opcode_fetch_q |-> qual && rw_read_q)
        else $error("Opcode fetch is not a qualified read.");
    a_fetch_follows: assert property (instr_done_q |=> opcode_fetch_q)
        else $error("No opcode fetch after the last cycle.");
    a_second_cycle: assert property (opcode_fetch_q |=> qual && rw_read_q && addr_q == $past(addr_q) + 16'h0001)
        else $error("Second cycle does not read the next program byte.");
    a_min_length: assert property (opcode_fetch_q |-> !instr_done_q)
        else $error("Instruction ended in its fetch cycle.");
    a_max_length: assert property (opcode_fetch_q |-> ##[1:7] instr_done_q)
        else $error("Instruction ran past eight cycles.");
    a_write_drives: assert property (wr |-> data_oe_q)
        else $error("Write cycle without data drive.");
    a_read_floats: assert property (rw_read_q |-> !data_oe_q)
        else $error("Data driven while read is selected.");
    a_write_pair: assert property ($past(wr) && wr |-> addr_q == $past(addr_q) + 16'h0001 || addr_q == $past(addr_q) - 16'h0001)
        else $error("Consecutive writes are not at adjacent addresses.");
    a_idle_run: assert property (!qual [*3] |=> qual)
        else $error("More than three unqualified cycles in a row.");
endmodule

bind cbs_sequencer cbs_seq_sva u_chk (
    .clk                            (clk),
    .rst                            (rst),
    .addr_q                         (addr_q),
    .valid_memory_address_qualifier (valid_memory_address_qualifier),
    .rw_read_q                      (rw_read_q),
    .data_oe_q                      (data_oe_q),
    .opcode_fetch_q                 (opcode_fetch_q),
    .instr_done_q                   (instr_done_q)
);

// file: tb/cbs_mem_model.sv
module cbs_mem_model (
    input  wire logic        clk,
    input  wire logic [15:0] addr,
    input  wire logic        qual,
    input  wire logic        rw_read,
    input  wire logic [7:0]  wdata,
    output logic      [7:0]  rdata
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [7:0] mem [0:65535];
    logic [7:0] last_q = 8'h00;
    // Unselected reads see a floating bus; with no pull the inverse of the last value is shown, so a
    // design that samples it cannot match by chance.
    always_comb rdata = (qual && rw_read) ? mem[addr] : ~last_q;
    always @(posedge clk) begin
        last_q <= rdata;
        if (qual && !rw_read) begin
            mem[addr] <= wdata;
        end
    end
endmodule

// file: tb/testbench.sv
`include "cbs_regs.vh"
module testbench;
    timeunit 1ns;
    timeprecision 1ns;
    localparam int N_DIR = 36;
    localparam int N_ALL = 336;
    localparam int LIMIT = 6000;
    logic        clk = 1'b0;
    logic        rst = 1'b1;
    logic [4:0]  group = 5'h00;
    logic        test_op = 1'b0;
    logic [15:0] ix = 16'h0000;
    logic [15:0] sp = 16'h0000;
    logic [15:0] sw = 16'h0000;
    logic [7:0]  din, dout, b1, b2;
    logic [15:0] addr, pc, opa, ixo, ixc, ret, pcq;
    logic [1:0]  duse;
    logic        qual, rw, oe, fet, done;
    logic [4:0]  g;
    int          errors = 0, checked = 0, tick = 0, cyc = 0, len = 0, n = 0, seed = 87;
    byte         c;
    string       s;

    always #5 clk = ~clk;

    cbs_sequencer DUT (
        .clk                            (clk),
        .rst                            (rst),
        .group                          (group),
        .zero_minus_test_op             (test_op),
        .index_reg                      (ix),
        .stack_ptr                      (sp),
        .store_word                     (sw),
        .data_in                        (din),
        .addr_q                         (addr),
        .valid_memory_address_qualifier (qual),
        .rw_read_q                      (rw),
        .data_out_q                     (dout),
        .data_oe_q                      (oe),
        .data_use_q                     (duse),
        .opcode_fetch_q                 (fet),
        .instr_done_q                   (done),
        .pc_q                           (pcq)
    );
    cbs_mem_model mdl (
        .clk     (clk),
        .addr    (addr),
        .qual    (qual),
        .rw_read (rw),
        .wdata   (dout),
        .rdata   (din)
    );

    // Three letters per cycle: address source, qualifier (? is low for the test op), read or write.
    function automatic string seq(input logic [4:0] k);
        case (k)
            `CBS_GRP_IMM8:    return "p1rq1r";
            `CBS_GRP_IMM16:   return "p1rq1rs1r";
            `CBS_GRP_DIR8:    return "p1rq1ro1r";
            `CBS_GRP_DIR16:   return "p1rq1ro1rn1r";
            `CBS_GRP_DIR_STA: return "p1rq1ro0ro1w";
            `CBS_GRP_DIR_STR: return "p1rq1ro0ro1wn1w";
            `CBS_GRP_IDX_JMP: return "p1rq1rx0rc0r";
            `CBS_GRP_IDX8:    return "p1rq1rx0rc0ri1r";
            `CBS_GRP_IDX16:   return "p1rq1rx0rc0ri1rj1r";
            `CBS_GRP_IDX_STA: return "p1rq1rx0rc0ri0ri1w";
            `CBS_GRP_IDX_RMW: return "p1rq1rx0rc0ri1ri0ri?w";
            `CBS_GRP_IDX_STR: return "p1rq1rx0rc0ri0ri1wj1w";
            `CBS_GRP_IDX_JSR: return "p1rq1rx0rk1wl1wm0rx0rc0r";
            `CBS_GRP_EXT_JMP: return "p1rq1rs1r";
            `CBS_GRP_EXT8:    return "p1rq1rs1ro1r";
            `CBS_GRP_EXT16:   return "p1rq1rs1ro1rn1r";
            `CBS_GRP_EXT_STA: return "p1rq1rs1ro0ro1w";
            default:          return "p1rq1rs1ro1ro0ro?w";
        endcase
    endfunction

    function automatic logic [15:0] ea(input byte k);
        case (k)
            "p": return pc;
            "q": return pc + 16'h0001;
            "s": return pc + 16'h0002;
            "o": return opa;
            "n": return opa + 16'h0001;
            "x": return ix;
            "c": return ixc;
            "i": return ixo;
            "j": return ixo + 16'h0001;
            "k": return sp;
            "l": return sp - 16'h0001;
            default: return sp - 16'h0002;
        endcase
    endfunction

    function automatic logic [7:0] wd(input byte k);
        case (k)
            "k": return ret[7:0];
            "l": return ret[15:8];
            "n", "j": return sw[7:0];
            default: return (g == `CBS_GRP_DIR_STR || g == `CBS_GRP_IDX_STR) ? sw[15:8] : sw[7:0];
        endcase
    endfunction

    function automatic logic [1:0] du();
        if (s[3 * cyc - 2] == "0") return `CBS_DAT_NONE;
        if (s[3 * cyc - 1] == "r") return `CBS_DAT_READ;
        if (c == "l" || (c != "n" && c != "j" && (g == `CBS_GRP_DIR_STR || g == `CBS_GRP_IDX_STR))) return `CBS_DAT_WHI;
        return `CBS_DAT_WLO;
    endfunction

    function automatic logic [15:0] npc();
        case (g)
            `CBS_GRP_IDX_JMP, `CBS_GRP_IDX_JSR: return ixo;
            `CBS_GRP_EXT_JMP: return {b1, b2};
            `CBS_GRP_IMM16, `CBS_GRP_EXT8, `CBS_GRP_EXT16, `CBS_GRP_EXT_STA, `CBS_GRP_EXT_RMW: return pc + 16'h0003;
            default: return pc + 16'h0002;
        endcase
    endfunction

    task automatic cmp1(input string what, input logic e, input logic v);
        checked++;
        if (v !== e) begin
            errors++;
            $display("CHECK FAILED %s expected %0b seen %0b", what, e, v);
        end
    endtask

    task automatic cmp16(input string what, input logic [15:0] e, input logic [15:0] v);
        checked++;
        if (v !== e) begin
            errors++;
            $display("CHECK FAILED %s expected %h seen %h", what, e, v);
        end
    endtask

    task automatic end_of_test();
        $display("Comparisons %0d, mismatches %0d", checked, errors);
        if (errors == 0 && checked > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask

    initial begin
        for (int i = 0; i < 65536; i++) begin
            mdl.mem[i] = 8'($random(seed));
        end
    end

    // One process both checks and drives, so checks always see this cycle's values before any change.
    always @(negedge clk) begin
        tick++;
        if (tick == 16) begin
            rst = 1'b0;
        end
        if (tick > LIMIT) begin
            errors++;
            $display("CHECK FAILED run length expected below %0d seen %0d", LIMIT, tick);
            end_of_test();
        end else begin
            if (tick >= 17) begin
                if (cyc == len) begin
                    pc = (len != 0) ? npc() : 16'h0000;
                    g = group;
                    b1 = mdl.mem[pc + 16'h0001];
                    b2 = mdl.mem[pc + 16'h0002];
                    ix = 16'($random(seed));
                    sp = 16'($random(seed));
                    sw = 16'($random(seed));
                    n++;
                    test_op = (n <= N_DIR) ? (n > 18) : 1'($random(seed));
                    opa = (g >= `CBS_GRP_EXT_JMP) ? {b1, b2} : {8'h00, b1};
                    ixo = ix + {8'h00, b1};
                    ixc = {ix[15:8], ix[7:0] + b1};
                    ret = pc + 16'h0002;
                    s = seq(g);
                    len = s.len() / 3;
                    cyc = 1;
                end else begin
                    cyc++;
                end
                c = s[3 * cyc - 3];
                cmp1("opcode fetch", cyc == 1, fet);
                cmp1("last cycle", cyc == len, done);
                cmp16("address", ea(c), addr);
                cmp1("qualifier", s[3 * cyc - 2] == "1" || (s[3 * cyc - 2] == "?" && !test_op), qual);
                cmp1("read select", s[3 * cyc - 1] == "r", rw);
                cmp1("data drive", s[3 * cyc - 1] == "w", oe);
                cmp16("data use", {14'h0000, du()}, {14'h0000, duse});
                if (cyc == 1) begin
                    cmp16("program address", pc + 16'h0001, pcq);
                end
                if (s[3 * cyc - 1] == "w" && qual === 1'b1) begin
                    cmp16("write data", {8'h00, wd(c)}, {8'h00, dout});
                end
            end
            if (tick >= 16 && cyc == len) begin
                if (n == N_DIR) begin
                    $display("Directed pass over every group finished");
                end
                if (n == N_ALL) begin
                    $display("Random instruction stream finished");
                    end_of_test();
                end else begin
                    group = 5'((n < N_DIR) ? n % 18 : {$random(seed)} % 18);
                end
            end
        end
    end
endmodule
